/* rtl/clock_output_pin_pkg.sv */
// package: register map, field positions, reset values and types for the clock output block
package clock_output_pin_pkg;
   // ==========================================================
   // register map (byte addresses, AXI4-Lite)
   localparam logic [7:0] ctrl0_addr     = 8'h00;
   localparam logic [7:0] ctrl1_addr     = 8'h04;
   localparam logic [7:0] protect_addr   = 8'h08;
   localparam logic [7:0] mode_addr      = 8'h0C;
   localparam logic [7:0] div_addr       = 8'h10;
   localparam logic [7:0] exit_prio_addr = 8'h14;
   localparam logic [7:0] status_addr    = 8'h18;
   // ==========================================================
   // field positions
   localparam int sel_lo_pos      = 0;
   localparam int wait_stop_pos   = 2;
   localparam int main_stop_pos   = 5;
   localparam int all_stop_pos    = 0;
   localparam int drive_pos       = 5;
   localparam int protect_pos     = 0;
   localparam int enable_sel_pos  = 7;
   localparam int latch_lo_pos    = 4;
   localparam int mem_mode_pos    = 0;
   localparam int low_speed_pos   = 1;
   // ==========================================================
   // reset values and encodings
   localparam logic [7:0] ctrl0_reset  = 8'h08;
   localparam logic [7:0] ctrl1_reset  = 8'h20;
   localparam logic [7:0] div8_value   = 8'h08;
   localparam logic [1:0] sel_port     = 2'h0;
   localparam logic [1:0] sel_sub      = 2'h1;
   localparam logic [1:0] sel_div8     = 2'h2;
   localparam logic [1:0] sel_div32    = 2'h3;
   localparam logic [1:0] latch_on_pin = 2'h1;
   localparam logic [1:0] resp_okay    = 2'h0;
   localparam logic [1:0] resp_slverr  = 2'h2;
   localparam int         div8_count   = 8;
   localparam int         div32_count  = 32;

   typedef enum logic [1:0] {
      pin_port,
      pin_clock,
      pin_low,
      pin_strobe
   } pin_role_t;

   // clocks and strobes that may reach the shared pin
   typedef struct packed {
      logic bus_clock;
      logic sub_clock;
      logic strobe;
   } pin_sources_t;

   // oscillator pin controls
   typedef struct packed {
      logic main_out_high;
      logic feedback_on;
      logic sub_pins_hiz;
   } osc_ctl_t;
endpackage

/* rtl/clock_output_and_stop_mode.sv */
// clock output pin selection, stop mode control and register slave
// Contract
// (RQ1) single-chip, enable 1: pin carries sub, div8 or div32 clock per select
// (RQ2) single-chip, select 00: pin stays port pin, bus clock never output
// (RQ3) expansion mode, strobe not 01, enable 1: sub, div8 or div32 clock out
// (RQ4) expansion mode, strobe not 01, enable 0, select 00: bus clock out
// (RQ5) expansion mode, strobe not 01, enable 1, select 00: pin driven low, no port
// (RQ6) strobe select 01 and select 00: enable ignored, latch strobe out
// (RQ7) wait-stop bit 1: div8/div32 output halts once wait executes
// (RQ8) writing all-stop bit 1 halts oscillators, enters stop mode
// (RQ9) in stop mode internal clocks halt; external-clocked units keep running
// (RQ10) stop left by reset or interrupt; interrupt routine then runs
// (RQ11) wake only by enabled interrupt with priority above exit level
// (RQ12) software sets exit level equal to processor level before stop
// (RQ13) stop entry and reset load division register with 08
// (RQ14) main clock stopped forces division register to divide-by-8
// (RQ15) control register 1 writes accepted only while protect bit 0 is 1
// (RQ16) drive bit set on reset and fast-mode stop entry; kept in low-speed
// (RQ17) all-stop: main osc output high, feedback off, sub pins high-z
// (RQ18) in stop: pin high for sub clock, holds level for div8/div32
// (RQ19) self-refresh at stop entry: column and row strobes driven low
// (RQ20) select decode: 00 port, 01 sub, 10 div8, 11 div32
// (RQ21) source switches produce no runt pulses on the pin; the code takes a new source at the next clk edge without level matching
`timescale 1ns/1ps
module clock_output_and_stop_mode (
   input  wire logic                     clk_in,
   input  wire logic                     rst_in,
   input  wire logic [7:0]               s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [7:0]               s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   input  wire clock_output_pin_pkg::pin_sources_t sources_in,
   input  wire logic                     wait_exec_in,
   input  wire logic                     int_req_in,
   input  wire logic [2:0]               int_prio_in,
   input  wire logic                     self_refresh_in,
   input  wire logic                     port_data_in,
   input  wire logic                     port_dir_in,
   output logic                          clock_output_pin_out,
   output logic                          clock_output_pin_oe_out,
   output logic                          stop_mode_out,
   output logic                          wake_int_out,
   output logic                          osc_halt_out,
   output logic                          dram_strobes_low_out,
   output clock_output_pin_pkg::osc_ctl_t          osc_ctl_out,
   output logic [7:0]                    main_div_out
);
   // ==========================================================
   // synchronisers for asynchronous pin sources
   logic [2:0] src_meta;
   logic [2:0] src_sync;
   always_ff @(posedge clk_in) begin
      src_meta <= sources_in;
      src_sync <= src_meta;
   end
   wire bus_clk_s = src_sync[2];
   wire sub_clk_s = src_sync[1];
   wire strobe_s  = src_sync[0];

   // ==========================================================
   // registers
   logic [7:0] ctrl0, next_ctrl0;
   logic [7:0] ctrl1, next_ctrl1;
   logic [7:0] protect, next_protect;
   logic [7:0] proc_mode, next_proc_mode;
   logic [7:0] main_div, next_main_div;
   logic [2:0] exit_prio, next_exit_prio;
   logic       stopped, next_stopped;
   logic       waiting, next_waiting;
   logic       wake, next_wake;
   logic       refresh_low, next_refresh_low;

   // bus handshake state
   logic       aw_held, next_aw_held;
   logic       w_held, next_w_held;
   // strobe captured with the data: the master may change wstrb once W is taken
   logic       w_strb0, next_w_strb0;
   logic [7:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic       b_pend, next_b_pend;
   logic [1:0] b_resp, next_b_resp;
   logic       r_pend, next_r_pend;
   logic [31:0] r_data, next_r_data;
   logic [1:0] r_resp, next_r_resp;

   wire do_write = aw_held && w_held && !b_pend;
   wire do_read  = s_axi_arvalid && !r_pend;

   // ==========================================================
   // peripheral dividers: toggling div8/div32 square-wave levels; counters freeze in stop
   logic [4:0] div_cnt, next_div_cnt;
   logic       div8_lvl, next_div8_lvl;
   logic       div32_lvl, next_div32_lvl;
   wire periph_run = !stopped && !ctrl0[clock_output_pin_pkg::main_stop_pos]
                     && !(waiting && ctrl0[clock_output_pin_pkg::wait_stop_pos]); // RQ7 RQ9

   always_comb begin
      next_div_cnt   = div_cnt;
      next_div8_lvl  = div8_lvl;
      next_div32_lvl = div32_lvl;
      if (periph_run) begin
         next_div_cnt = div_cnt + 5'h01;
         if (div_cnt[1:0] == 2'h3)
            next_div8_lvl = !div8_lvl;
         if (div_cnt == 5'h0F || div_cnt == 5'h1F)
            next_div32_lvl = !div32_lvl;
      end
   end

   // ==========================================================
   // pin source decode
   wire [1:0] sel       = ctrl0[clock_output_pin_pkg::sel_lo_pos +: 2];
   wire       enable    = proc_mode[clock_output_pin_pkg::enable_sel_pos];
   wire [1:0] latch_sel = proc_mode[clock_output_pin_pkg::latch_lo_pos +: 2];
   wire       expanded  = proc_mode[clock_output_pin_pkg::mem_mode_pos];
   clock_output_pin_pkg::pin_role_t role;
   logic                  clk_pick;

   always_comb begin
      role     = clock_output_pin_pkg::pin_port;
      clk_pick = 1'b0;
      case (sel) // RQ20
         clock_output_pin_pkg::sel_sub:   clk_pick = stopped ? 1'b1 : sub_clk_s; // RQ18
         clock_output_pin_pkg::sel_div8:  clk_pick = div8_lvl;
         clock_output_pin_pkg::sel_div32: clk_pick = div32_lvl;
         default:               clk_pick = bus_clk_s;
      endcase
      if (!expanded) begin
         if (enable && sel != clock_output_pin_pkg::sel_port)
            role = clock_output_pin_pkg::pin_clock; // RQ1
         else
            role = clock_output_pin_pkg::pin_port; // RQ2
      end else if (sel == clock_output_pin_pkg::sel_port && latch_sel == clock_output_pin_pkg::latch_on_pin) begin
         role = clock_output_pin_pkg::pin_strobe; // RQ6
      end else if (sel == clock_output_pin_pkg::sel_port) begin
         role = enable ? clock_output_pin_pkg::pin_low : clock_output_pin_pkg::pin_clock; // RQ4 RQ5
      end else begin
         role = enable ? clock_output_pin_pkg::pin_clock : clock_output_pin_pkg::pin_low; // RQ3
      end
   end

   // registered switch: new source taken at the next clk edge, with no check that old and new levels agree
   logic      pin_lvl, next_pin_lvl;
   logic      pin_oe, next_pin_oe;
   always_comb begin
      next_pin_oe  = (role != clock_output_pin_pkg::pin_port) || port_dir_in;
      next_pin_lvl = pin_lvl;
      case (role)
         clock_output_pin_pkg::pin_clock:  next_pin_lvl = clk_pick; // RQ21
         clock_output_pin_pkg::pin_strobe: next_pin_lvl = stopped ? 1'b1 : strobe_s;
         clock_output_pin_pkg::pin_low:    next_pin_lvl = 1'b0;
         default:                next_pin_lvl = port_data_in;
      endcase
   end

   // ==========================================================
   // stop mode and register next-state
   logic [7:0] wd;
   always_comb begin
      next_ctrl0       = ctrl0;
      next_ctrl1       = ctrl1;
      next_protect     = protect;
      next_proc_mode   = proc_mode;
      next_main_div    = main_div;
      next_exit_prio   = exit_prio;
      next_stopped     = stopped;
      next_waiting     = waiting;
      next_wake        = 1'b0;
      next_refresh_low = refresh_low;
      wd               = w_data[7:0];
      if (do_write && w_strb0) begin
         if (aw_addr == clock_output_pin_pkg::ctrl0_addr && protect[clock_output_pin_pkg::protect_pos])
            next_ctrl0 = wd;
         else if (aw_addr == clock_output_pin_pkg::ctrl1_addr && protect[clock_output_pin_pkg::protect_pos])
            next_ctrl1 = wd; // RQ15
         else if (aw_addr == clock_output_pin_pkg::protect_addr)
            next_protect = wd;
         else if (aw_addr == clock_output_pin_pkg::mode_addr)
            next_proc_mode = wd;
         else if (aw_addr == clock_output_pin_pkg::div_addr)
            next_main_div = wd;
         else if (aw_addr == clock_output_pin_pkg::exit_prio_addr)
            next_exit_prio = wd[2:0]; // RQ12
      end
      if (wait_exec_in && !stopped)
         next_waiting = 1'b1;
      if (next_ctrl1[clock_output_pin_pkg::all_stop_pos] && !stopped) begin
         next_stopped     = 1'b1; // RQ8
         next_main_div    = clock_output_pin_pkg::div8_value; // RQ13
         next_refresh_low = self_refresh_in; // RQ19
         if (!proc_mode[clock_output_pin_pkg::low_speed_pos])
            next_ctrl1[clock_output_pin_pkg::drive_pos] = 1'b1; // RQ16
      end
      if (next_ctrl0[clock_output_pin_pkg::main_stop_pos])
         next_main_div = clock_output_pin_pkg::div8_value; // RQ14
      if ((stopped || waiting) && int_req_in && int_prio_in > exit_prio) begin
         next_stopped     = 1'b0; // RQ10 RQ11
         next_waiting     = 1'b0;
         next_wake        = 1'b1;
         next_refresh_low = 1'b0;
         next_ctrl1[clock_output_pin_pkg::all_stop_pos] = 1'b0;
      end
   end

   // ==========================================================
   // AXI4-Lite slave next-state
   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_strb0 = w_strb0;
      next_b_pend  = b_pend;
      next_b_resp  = b_resp;
      next_r_pend  = r_pend;
      next_r_data  = r_data;
      next_r_resp  = r_resp;
      if (s_axi_awvalid && !aw_held) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb0 = s_axi_wstrb[0];
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_b_pend  = 1'b1;
         next_b_resp  = (aw_addr > clock_output_pin_pkg::status_addr || aw_addr[1:0] != 2'h0
                         || aw_addr == clock_output_pin_pkg::status_addr)
                        ? clock_output_pin_pkg::resp_slverr : clock_output_pin_pkg::resp_okay;
      end
      if (b_pend && s_axi_bready)
         next_b_pend = 1'b0;
      if (r_pend && s_axi_rready)
         next_r_pend = 1'b0;
      if (do_read) begin
         next_r_pend = 1'b1;
         next_r_resp = clock_output_pin_pkg::resp_okay;
         if (s_axi_araddr == clock_output_pin_pkg::ctrl0_addr)
            next_r_data = {24'h000000, ctrl0};
         else if (s_axi_araddr == clock_output_pin_pkg::ctrl1_addr)
            next_r_data = {24'h000000, ctrl1};
         else if (s_axi_araddr == clock_output_pin_pkg::protect_addr)
            next_r_data = {24'h000000, protect};
         else if (s_axi_araddr == clock_output_pin_pkg::mode_addr)
            next_r_data = {24'h000000, proc_mode};
         else if (s_axi_araddr == clock_output_pin_pkg::div_addr)
            next_r_data = {24'h000000, main_div};
         else if (s_axi_araddr == clock_output_pin_pkg::exit_prio_addr)
            next_r_data = {29'h00000000, exit_prio};
         else if (s_axi_araddr == clock_output_pin_pkg::status_addr)
            next_r_data = {28'h0000000, role, waiting, stopped};
         else begin
            next_r_data = 32'h00000000;
            next_r_resp = clock_output_pin_pkg::resp_slverr;
         end
      end
   end

   // ==========================================================
   // state registers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ctrl0       <= clock_output_pin_pkg::ctrl0_reset;
         ctrl1       <= clock_output_pin_pkg::ctrl1_reset; // RQ16
         protect     <= 8'h00;
         proc_mode   <= 8'h00;
         main_div    <= clock_output_pin_pkg::div8_value; // RQ13
         exit_prio   <= 3'h0;
         stopped     <= 1'b0; // RQ10
         waiting     <= 1'b0;
         wake        <= 1'b0;
         refresh_low <= 1'b0;
         div_cnt     <= 5'h00;
         div8_lvl    <= 1'b0;
         div32_lvl   <= 1'b0;
         pin_lvl     <= 1'b0;
         pin_oe      <= 1'b0;
         aw_held     <= 1'b0;
         w_held      <= 1'b0;
         aw_addr     <= 8'h00;
         w_data      <= 32'h00000000;
         w_strb0     <= 1'b0;
         b_pend      <= 1'b0;
         b_resp      <= clock_output_pin_pkg::resp_okay;
         r_pend      <= 1'b0;
         r_data      <= 32'h00000000;
         r_resp      <= clock_output_pin_pkg::resp_okay;
      end else begin
         ctrl0       <= next_ctrl0;
         ctrl1       <= next_ctrl1;
         protect     <= next_protect;
         proc_mode   <= next_proc_mode;
         main_div    <= next_main_div;
         exit_prio   <= next_exit_prio;
         stopped     <= next_stopped;
         waiting     <= next_waiting;
         wake        <= next_wake;
         refresh_low <= next_refresh_low;
         div_cnt     <= next_div_cnt;
         div8_lvl    <= next_div8_lvl;
         div32_lvl   <= next_div32_lvl;
         pin_lvl     <= next_pin_lvl;
         pin_oe      <= next_pin_oe;
         aw_held     <= next_aw_held;
         w_held      <= next_w_held;
         aw_addr     <= next_aw_addr;
         w_data      <= next_w_data;
         w_strb0     <= next_w_strb0;
         b_pend      <= next_b_pend;
         b_resp      <= next_b_resp;
         r_pend      <= next_r_pend;
         r_data      <= next_r_data;
         r_resp      <= next_r_resp;
      end
   end

   // ==========================================================
   // outputs
   assign s_axi_awready           = !aw_held;
   assign s_axi_wready            = !w_held;
   assign s_axi_bvalid            = b_pend;
   assign s_axi_bresp             = b_resp;
   assign s_axi_arready           = !r_pend;
   assign s_axi_rvalid            = r_pend;
   assign s_axi_rdata             = r_data;
   assign s_axi_rresp             = r_resp;
   assign clock_output_pin_out    = pin_lvl;
   assign clock_output_pin_oe_out = pin_oe;
   assign stop_mode_out           = stopped; // RQ9
   assign osc_halt_out            = stopped;
   assign wake_int_out            = wake;
   assign dram_strobes_low_out    = refresh_low;
   assign main_div_out            = main_div;
   assign osc_ctl_out             = '{main_out_high: ctrl1[clock_output_pin_pkg::all_stop_pos], // RQ17
                                      feedback_on:   !ctrl1[clock_output_pin_pkg::all_stop_pos],
                                      sub_pins_hiz:  ctrl1[clock_output_pin_pkg::all_stop_pos]};

   // ==========================================================
   // assertions
   sequence stop_write_s;
      do_write && w_strb0 && aw_addr == clock_output_pin_pkg::ctrl1_addr
      && protect[clock_output_pin_pkg::protect_pos] && w_data[0] && !stopped;
   endsequence

   a_stop_entry: assert property (@(posedge clk_in) disable iff (rst_in) // RQ8
      stop_write_s |=> stopped) else $error("stop not entered");
   a_div_on_stop: assert property (@(posedge clk_in) disable iff (rst_in) // RQ13
      stop_write_s |=> main_div == 8'h08) else $error("divider not 08 on stop");
   a_protect_block: assert property (@(posedge clk_in) disable iff (rst_in) // RQ15
      (!protect[0] && !stopped && !waiting) |=> ctrl1[0] == $past(ctrl1[0]))
      else $error("ctrl1 changed without protect");
   a_wake_prio: assert property (@(posedge clk_in) disable iff (rst_in) // RQ11
      wake |-> $past(int_prio_in) > $past(exit_prio)) else $error("wake below level");
   a_sc_no_bus: assert property (@(posedge clk_in) disable iff (rst_in) // RQ2
      (!expanded && sel == 2'h0)
      |=> pin_lvl == $past(port_data_in) && pin_oe == $past(port_dir_in))
      else $error("port role lost");
   a_strobe_role: assert property (@(posedge clk_in) disable iff (rst_in) // RQ6
      (expanded && sel == 2'h0 && latch_sel == 2'h1)
      |=> pin_lvl == ($past(stopped) ? 1'b1 : $past(strobe_s)))
      else $error("strobe not on pin");
   a_low_drive: assert property (@(posedge clk_in) disable iff (rst_in) // RQ5
      (expanded && enable && sel == 2'h0 && latch_sel != 2'h1) |=> !pin_lvl && pin_oe)
      else $error("pin not low");
   a_osc_stop: assert property (@(posedge clk_in) disable iff (rst_in) // RQ17
      stopped |-> osc_ctl_out.main_out_high && osc_ctl_out.sub_pins_hiz
                  && !osc_ctl_out.feedback_on)
      else $error("osc not parked");
endmodule

/* dv/clock_output_and_stop_mode_bench.sv */
// testbench: pin selection table, protect, divider forcing, stop entry and wake
`timescale 1ns/1ps
module clock_output_and_stop_mode_bench;
   // ==========================================================
   // signals
   logic                     clk = 1'b0;
   logic                     rst = 1'b1;
   logic [7:0]               awaddr = 8'h00, araddr = 8'h00;
   logic [31:0]              wdata = 32'h0, rd;
   logic [3:0]               wstrb = 4'hF;
   logic                     awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic                     awready, wready, bvalid, arready, rvalid;
   logic [1:0]               bresp, rresp, rsp;
   logic [31:0]              rdata;
   clock_output_pin_pkg::pin_sources_t src = '0;
   logic                     wait_exec = 0, int_req = 0, self_ref = 0;
   logic [2:0]               int_prio = 3'h0;
   logic                     pin, pin_oe, stop, wake, halt, dram_low, last;
   clock_output_pin_pkg::osc_ctl_t     osc;
   logic [7:0]               main_div, cnt = 8'h00;
   int                       failures = 0, n_tests = 0, cycles = 0, k, n;
   logic [11:0]              rows [9];

   always #2 clk = ~clk;
   // sources at 1/4 (bus), 1/64 (sub) and 1/16 (strobe) of the clk rate so the registered pin cannot make runts
   always @(posedge clk) begin
      cnt <= cnt + 8'h01;
      src <= {cnt[1], cnt[5], cnt[3]};
   end

   clock_output_and_stop_mode uut (
      .clk_in(clk), .rst_in(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sources_in(src),
      .wait_exec_in(wait_exec), .int_req_in(int_req), .int_prio_in(int_prio),
      .self_refresh_in(self_ref), .port_data_in(1'b1), .port_dir_in(1'b1),
      .clock_output_pin_out(pin), .clock_output_pin_oe_out(pin_oe),
      .stop_mode_out(stop), .wake_int_out(wake), .osc_halt_out(halt),
      .dram_strobes_low_out(dram_low), .osc_ctl_out(osc), .main_div_out(main_div));

   // ==========================================================
   // tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_done, w_done;
      aw_done = 0;
      w_done = 0;
      @(posedge clk);
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      while (!(aw_done && w_done)) begin
         @(posedge clk);
         if (awvalid && awready) begin aw_done = 1; awvalid <= 0; end
         if (wvalid && wready) begin w_done = 1; wvalid <= 0; end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 0;
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 0;
      do @(posedge clk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 0;
   endtask

   task automatic wait_stop(input logic lvl);
      for (int i = 0; i < 20 && stop !== lvl; i++) @(posedge clk);
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // a hung handshake ends the run here
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         final_report();
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      // {mode, select, role}: mode b0 expansion, b5:4 strobe select, b7 enable
      rows = '{{8'h80, 2'h1, 2'h1}, {8'h80, 2'h3, 2'h1}, {8'h80, 2'h0, 2'h0},
               {8'h00, 2'h0, 2'h0}, {8'h81, 2'h2, 2'h1}, {8'h01, 2'h0, 2'h1},
               {8'h81, 2'h0, 2'h2}, {8'h11, 2'h0, 2'h3}, {8'h91, 2'h0, 2'h3}};
      repeat (20) @(posedge clk);
      rst <= 0;
      check(main_div, 8'h08);
      check({stop, pin_oe}, 2'h0);
      axr(clock_output_pin_pkg::ctrl1_addr, rd, rsp); check(rd, 32'h20);
      // writes without the protect bit leave ctrl0 alone
      axw(clock_output_pin_pkg::ctrl0_addr, 32'h03, rsp);
      axr(clock_output_pin_pkg::ctrl0_addr, rd, rsp); check(rd, 32'h08);
      // an unprotected all-stop write must neither land nor stop the clocks
      axw(clock_output_pin_pkg::ctrl1_addr, 32'h01, rsp);
      axr(clock_output_pin_pkg::ctrl1_addr, rd, rsp); check(rd, 32'h20);
      check(stop, 1'b0);
      axw(clock_output_pin_pkg::protect_addr, 32'h01, rsp);
      $display("reset and protect test done");
      for (k = 0; k < 9; k++) begin
         axw(clock_output_pin_pkg::mode_addr, rows[k][11:4], rsp);
         axw(clock_output_pin_pkg::ctrl0_addr, rows[k][3:2], rsp);
         axr(clock_output_pin_pkg::status_addr, rd, rsp);
         check(rd[3:2], rows[k][1:0]);
         repeat (6) @(posedge clk);
         if (rows[k][1:0] == 2'h2) check({pin, pin_oe}, 2'h1);
         if (rows[k][1:0] == 2'h0) check({pin, pin_oe}, 2'h3);
         if (rows[k][1:0] == 2'h1) begin
            last = pin;
            n = 0;
            repeat (40) begin
               @(posedge clk);
               if (pin !== last) n++;
               last = pin;
            end
            check(n > 0, 1'b1);
         end
      end
      $display("pin selection table done");
      // div8 output frozen once wait executes with the stop bit set
      axw(clock_output_pin_pkg::mode_addr, 32'h80, rsp);
      axw(clock_output_pin_pkg::ctrl0_addr, 32'h06, rsp);
      wait_exec <= 1;
      @(posedge clk) wait_exec <= 0;
      repeat (6) @(posedge clk);
      last = pin;
      k = 0;
      repeat (40) begin @(posedge clk); if (pin !== last) k++; end
      check(k, 0);
      int_req <= 1; int_prio <= 3'h7;
      repeat (4) @(posedge clk);
      int_req <= 0;
      $display("wait stop test done");
      // main clock stop forces divide-by-8
      axw(clock_output_pin_pkg::div_addr, 32'h02, rsp);
      check(main_div, 8'h02);
      axw(clock_output_pin_pkg::ctrl0_addr, 32'h21, rsp);
      @(posedge clk); check(main_div, 8'h08);
      axw(clock_output_pin_pkg::ctrl0_addr, 32'h01, rsp);
      axw(clock_output_pin_pkg::div_addr, 32'h02, rsp);
      axw(clock_output_pin_pkg::ctrl1_addr, 32'h00, rsp);
      axw(clock_output_pin_pkg::exit_prio_addr, 32'h03, rsp);
      self_ref <= 1;
      axw(clock_output_pin_pkg::ctrl1_addr, 32'h01, rsp);
      wait_stop(1'b1);
      check({stop, halt, dram_low}, 3'h7);
      check(main_div, 8'h08);
      check(osc, 3'h5);
      k = 0;
      repeat (40) begin @(posedge clk); if (pin !== 1'b1) k++; end
      check(k, 0);
      axr(clock_output_pin_pkg::ctrl1_addr, rd, rsp); check(rd[5], 1'b1);
      // equal priority must not wake, higher priority must
      int_req <= 1; int_prio <= 3'h3;
      repeat (12) @(posedge clk);
      check({stop, wake}, 2'h2);
      int_prio <= 3'h4;
      k = 0;
      repeat (12) begin @(posedge clk); if (wake === 1'b1) k++; end
      check({k[1:0], stop}, 3'h2);
      int_req <= 0; self_ref <= 0;
      $display("stop and wake test done");
      // low-speed stop keeps the drive bit; a reset mid-stop restores everything
      axw(clock_output_pin_pkg::mode_addr, 32'h82, rsp);
      axw(clock_output_pin_pkg::ctrl1_addr, 32'h01, rsp);
      axw(clock_output_pin_pkg::div_addr, 32'h02, rsp);
      axr(clock_output_pin_pkg::ctrl1_addr, rd, rsp); check(rd, 32'h01);
      check({stop, main_div}, {1'b1, 8'h02});
      rst <= 1;
      repeat (3) @(posedge clk);
      rst <= 0;
      check({stop, pin_oe, main_div}, {2'h0, 8'h08});
      axr(clock_output_pin_pkg::ctrl1_addr, rd, rsp); check(rd, 32'h20);
      $display("mid-run reset test done");
      axr(8'h1C, rd, rsp);
      check(rd, 32'h0);
      check(rsp, clock_output_pin_pkg::resp_slverr);
      axw(clock_output_pin_pkg::status_addr, 32'h0, rsp); check(rsp, clock_output_pin_pkg::resp_slverr);
      $display("unmapped access test done");
      final_report();
   end
endmodule
